// file: core/ccspll_pkg.sv
// Shared constants and carriers of the clock source and PLL start-up control.
// Assumes one 25 MHz system clock; fuse levels arrive as raw bit values.
package ccspll_pkg;

   // ************************************************************
   // register map and field layout
   // ************************************************************
   localparam logic [3:0] REG_PLL_CSR = 4'h0;
   localparam logic [3:0] REG_CLK_STAT = 4'h1;
   localparam int unsigned CSR_LOCK_BIT = 0;
   localparam int unsigned CSR_EN_BIT = 1;
   localparam int unsigned CSR_HALF_BIT = 2;
   localparam int unsigned CSR_TMR_BIT = 3;
   localparam int unsigned STAT_RUN_BIT = 7;
   localparam logic [7:0] CSR_RST = 8'h00;

   // ************************************************************
   // fuse encodings (1 = unprogrammed, 0 = programmed)
   // ************************************************************
   localparam logic [3:0] CLOCK_SELECT_FUSES_EXT = 4'h0;
   localparam logic [3:0] CLOCK_SELECT_FUSES_PLL = 4'h1;
   localparam logic [3:0] CLOCK_SELECT_FUSES_RC = 4'h2;
   localparam logic [3:0] CLOCK_SELECT_FUSES_WDT = 4'h3;
   localparam logic [1:0] CLOCK_SELECT_FUSES_LFX_TOP = 2'h1;
   localparam logic [1:0] SUT_NONE = 2'h0;
   localparam logic [1:0] SUT_4MS = 2'h1;
   localparam logic [1:0] SUT_64MS = 2'h2;
   localparam logic [1:0] SUT_DEFAULT = 2'h2;
   localparam logic DIV8_PROGRAMMED = 1'b0;

   // ************************************************************
   // clock figures
   // ************************************************************
   localparam int unsigned CLK_SYS_KHZ = 25000;
   localparam int unsigned WDT_OSC_KHZ = 128;
   localparam int unsigned WDT_DIV = CLK_SYS_KHZ / WDT_OSC_KHZ;
   localparam int unsigned RC_MHZ = 8;
   localparam int unsigned PLL_MULT = 8;
   localparam logic [6:0] PCK_FULL_MHZ = 7'(RC_MHZ * PLL_MULT);
   localparam logic [2:0] SYS_PLL_DIV = 3'h4;
   localparam logic [2:0] SYS_NO_DIV = 3'h1;
   localparam int unsigned PLL_LOCK_US = 100;
   localparam logic [11:0] PLL_LOCK_CYC = 12'((PLL_LOCK_US * CLK_SYS_KHZ + 999) / 1000);

   // ************************************************************
   // start-up counts
   // ************************************************************
   localparam logic [14:0] CK_WAKE = 15'h0006;
   localparam logic [14:0] CK_RESET = 15'h000E;
   localparam logic [14:0] CK_1K = 15'h0400;
   localparam logic [14:0] CK_16K = 15'h4000;
   localparam logic [13:0] WDT_4MS = 14'h0200;
   localparam logic [13:0] WDT_64MS = 14'h2000;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0] {
      SLP_IDLE = 3'h0,
      SLP_ADCNR = 3'h1,
      SLP_PDOWN = 3'h2,
      SLP_PSAVE = 3'h3,
      SLP_STBY = 3'h4
   } ccspll_slp_t;

   typedef enum logic [4:0] {
      ST_LATCH = 5'h01,
      ST_WDT = 5'h02,
      ST_CK = 5'h04,
      ST_RUN = 5'h08,
      ST_SLEEP = 5'h10
   } ccspll_state_t;

   typedef struct packed {
      logic [3:0] clock_select_fuses;
      logic [1:0] startup_time_fuses;
      logic divide_by_eight_fuse;
   } ccspll_fuse_t;

   typedef struct packed {
      logic cpu_en;
      logic io_en;
      logic flash_en;
      logic adc_en;
      logic rc_run;
      logic pll_run;
      logic pll_lock_flag;
   } ccspll_gate_t;

   typedef struct packed {
      logic [3:0] sys_src;
      logic [2:0] sys_div;
      logic div8_init;
      logic pll_half_rate_select;
      logic [6:0] pck_mhz;
      logic tmr_fast_sel;
   } ccspll_cfg_t;

   typedef struct packed {
      logic port_b_line_four_clk;
      logic port_b_line_five_xtal;
   } ccspll_pin_t;

   localparam ccspll_fuse_t FUSE_DEFAULT = '{CLOCK_SELECT_FUSES_RC, SUT_DEFAULT, DIV8_PROGRAMMED};
   localparam ccspll_gate_t GATE_RST = 7'h08;

endpackage

// file: core/ccspll_tick_div.sv
// Enable-pulse divider: one-cycle tick every DIV cycles of clk_sys.
// Assumes the enable is synchronous to clk_sys.
`timescale 1ns/100ps
module ccspll_tick_div #(
   parameter int unsigned DIV = 2
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic en,
   output logic tick
);
   import ccspll_pkg::*;

   localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } ccspll_div_st_t;

   ccspll_div_st_t s_q;
   ccspll_div_st_t s_d;

   // ************************************************************
   // count and wrap
   // ************************************************************
   // tick held in the state so the output comes from a flop
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (en) begin
         if (s_q.cnt == LAST) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule // ccspll_tick_div

// file: core/ccspll_clock_ctrl.sv
// Clock source selection, PLL enable/lock and start-up timing controller.
// Assumes fuses, sleep requests, wake events and the selected-clock tick are
// synchronous to clk_sys; the oscillators and PLL themselves are analog.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module ccspll_clock_ctrl #(
   parameter logic [13:0] WDT_LONG_CNT = ccspll_pkg::WDT_64MS,
   parameter logic [14:0] CK_LONG_CNT = ccspll_pkg::CK_16K
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input ccspll_pkg::ccspll_fuse_t fuse_in,
   input wire logic fuse_blank,
   input wire logic sel_clk_tick,
   input wire logic sleep_req,
   input ccspll_pkg::ccspll_slp_t sleep_mode,
   input wire logic wake_evt,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output ccspll_pkg::ccspll_gate_t gate_out,
   output ccspll_pkg::ccspll_cfg_t cfg_out,
   output ccspll_pkg::ccspll_pin_t pin_out,
   output logic exec_en
);
   import ccspll_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      ccspll_state_t st;
      ccspll_fuse_t fz;
      ccspll_slp_t slp;
      logic pll_sw_enable;
      logic half;
      logic tmr_fast;
      logic [11:0] lock_cnt;
      logic [13:0] wdt_cnt;
      logic [13:0] wdt_tgt;
      logic [14:0] ck_cnt;
      logic [14:0] ck_tgt;
      logic [7:0] rdata;
      logic exec;
      ccspll_gate_t gate;
      ccspll_cfg_t cfg;
      ccspll_pin_t pins;
   } ccspll_main_st_t;

   ccspll_main_st_t s_q;
   ccspll_main_st_t s_d;

   logic wdt_tick;
   logic [28:0] tgt;
   logic deep_stop;
   logic pll_en;
   logic pll_sys;
   logic xtal_sel;

   // ************************************************************
   // watchdog oscillator time base
   // ************************************************************
   // the real-time part of start-up is timed from a 128 kHz tick
   ccspll_tick_div #(
      .DIV(WDT_DIV)
   ) u_wdt_div (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .en(1'b1),
      .tick(wdt_tick)
   );

   // ************************************************************
   // start-up targets
   // ************************************************************
   // returns {watchdog cycles, selected-clock cycles} for the latched fuses
   function automatic logic [28:0] start_tgt(input ccspll_fuse_t f,
                                              input logic from_rst);
      logic [13:0] w;
      logic [14:0] c;
      w = '0;
      c = '0;
      if (f.clock_select_fuses == CLOCK_SELECT_FUSES_PLL) begin
         // PLL source: clocks and real time both on wake and reset
         c = CK_RESET + (f.startup_time_fuses[0] ? CK_LONG_CNT : CK_1K);
         w = f.startup_time_fuses[1] ? WDT_LONG_CNT : WDT_4MS;
         if (from_rst) begin
            w = w + WDT_4MS;
         end
      end else if (from_rst) begin
         c = CK_RESET;
         case (f.startup_time_fuses)
            SUT_NONE: w = '0;
            SUT_4MS: w = WDT_4MS;
            SUT_64MS: w = WDT_LONG_CNT;
            default: w = WDT_LONG_CNT; // reserved code runs the safest delay
         endcase
      end else begin
         c = CK_WAKE;
      end
      return {w, c};
   endfunction

   // ************************************************************
   // combinational helpers
   // ************************************************************
   // targets follow the fuses already held, or the incoming ones at latch
   always_comb begin
      if (s_q.st == ST_LATCH) begin
         tgt = start_tgt(fuse_blank ? FUSE_DEFAULT : fuse_in, 1'b1);
      end else begin
         tgt = start_tgt(s_q.fz, 1'b0);
      end
   end

   // raw fuse values compare directly: zero bits are programmed ones
   // at latch the incoming fuses decide, so a write in that cycle cannot slip through
   assign pll_sys = (s_q.st == ST_LATCH) ?
                    (!fuse_blank && fuse_in.clock_select_fuses == CLOCK_SELECT_FUSES_PLL) :
                    (s_q.fz.clock_select_fuses == CLOCK_SELECT_FUSES_PLL);
   assign xtal_sel = s_q.fz.clock_select_fuses[3] ||
                     (s_q.fz.clock_select_fuses[3:2] == CLOCK_SELECT_FUSES_LFX_TOP);

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_d = s_q;
      s_d.rdata = 8'h00;

      // start-up and sleep sequence
      case (s_q.st)
         ST_LATCH: begin
            // fuses are frozen here until the next reset
            s_d.fz = fuse_blank ? FUSE_DEFAULT : fuse_in;
            s_d.wdt_tgt = tgt[28:15];
            s_d.ck_tgt = tgt[14:0];
            s_d.wdt_cnt = '0;
            s_d.ck_cnt = '0;
            s_d.st = ST_WDT;
         end
         ST_WDT: begin
            // real-time part, timed by the watchdog oscillator
            if (s_q.wdt_cnt == s_q.wdt_tgt) begin
               s_d.st = ST_CK;
            end else if (wdt_tick) begin
               s_d.wdt_cnt = s_q.wdt_cnt + 14'h0001;
            end
         end
         ST_CK: begin
            // oscillator settling, counted on the selected clock
            if (s_q.ck_cnt == s_q.ck_tgt) begin
               s_d.st = ST_RUN;
            end else if (sel_clk_tick) begin
               s_d.ck_cnt = s_q.ck_cnt + 15'h0001;
            end
         end
         ST_RUN: begin
            if (sleep_req) begin
               s_d.slp = sleep_mode;
               s_d.st = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wake_evt) begin
               // stopped oscillators need a start-up count before execution
               if (s_q.slp == SLP_PDOWN || s_q.slp == SLP_PSAVE ||
                   s_q.slp == SLP_STBY) begin
                  s_d.wdt_tgt = tgt[28:15];
                  s_d.ck_tgt = tgt[14:0];
                  s_d.wdt_cnt = '0;
                  s_d.ck_cnt = '0;
                  s_d.st = ST_WDT;
               end else begin
                  s_d.st = ST_RUN;
               end
            end
         end
         default: begin
            s_d.st = ST_LATCH;
         end
      endcase

      // register writes
      if (reg_wr && reg_addr == REG_PLL_CSR) begin
         s_d.pll_sw_enable = reg_wdata[CSR_EN_BIT];
         s_d.tmr_fast = reg_wdata[CSR_TMR_BIT];
         // a set attempt is dropped while the PLL clocks the system
         if (pll_sys) begin
            s_d.half = s_q.half & reg_wdata[CSR_HALF_BIT];
         end else begin
            s_d.half = reg_wdata[CSR_HALF_BIT];
         end
      end

      // register reads, data valid in the following cycle only
      if (reg_rd) begin
         case (reg_addr)
            REG_PLL_CSR: begin
               s_d.rdata[CSR_LOCK_BIT] = s_q.gate.pll_lock_flag;
               s_d.rdata[CSR_EN_BIT] = s_q.pll_sw_enable;
               s_d.rdata[CSR_HALF_BIT] = s_q.half;
               s_d.rdata[CSR_TMR_BIT] = s_q.tmr_fast;
            end
            REG_CLK_STAT: begin
               s_d.rdata = {s_q.exec, s_q.fz};
            end
            default: begin
               s_d.rdata = 8'h00;
            end
         endcase
      end

      // execution permitted only once start-up has finished
      s_d.exec = (s_d.st == ST_RUN);

      // oscillator and PLL power
      deep_stop = (s_d.st == ST_SLEEP) &&
                  (s_d.slp == SLP_PDOWN || s_d.slp == SLP_STBY);
      s_d.gate.rc_run = !deep_stop;
      pll_en = (s_d.pll_sw_enable ||
                s_d.fz.clock_select_fuses == CLOCK_SELECT_FUSES_PLL) && !deep_stop;
      s_d.gate.pll_run = pll_en;

      // lock: restarts whenever the PLL stops or its source rate changes
      if (!pll_en || (s_d.half != s_q.half)) begin
         s_d.lock_cnt = '0;
      end else if (s_q.lock_cnt != PLL_LOCK_CYC) begin
         s_d.lock_cnt = s_q.lock_cnt + 12'h001;
      end
      s_d.gate.pll_lock_flag = pll_en && (s_d.lock_cnt == PLL_LOCK_CYC);

      // clock domain gates
      s_d.gate.cpu_en = s_d.exec;
      s_d.gate.flash_en = s_d.exec;
      s_d.gate.io_en = s_d.exec ||
                       (s_d.st == ST_SLEEP && s_d.slp == SLP_IDLE);
      // converter keeps its own clock through the noise-reduction mode
      s_d.gate.adc_en = s_d.exec ||
                        (s_d.st == ST_SLEEP &&
                         (s_d.slp == SLP_IDLE || s_d.slp == SLP_ADCNR));

      // source and rate report
      s_d.cfg.sys_src = s_d.fz.clock_select_fuses;
      s_d.cfg.sys_div = (s_d.fz.clock_select_fuses == CLOCK_SELECT_FUSES_PLL) ?
                        SYS_PLL_DIV : SYS_NO_DIV;
      s_d.cfg.div8_init = (s_d.fz.divide_by_eight_fuse == DIV8_PROGRAMMED);
      s_d.cfg.pll_half_rate_select = s_d.half;
      if (!pll_en) begin
         s_d.cfg.pck_mhz = 7'h00;
      end else if (s_d.half) begin
         s_d.cfg.pck_mhz = PCK_FULL_MHZ >> 1;
      end else begin
         s_d.cfg.pck_mhz = PCK_FULL_MHZ;
      end
      s_d.cfg.tmr_fast_sel = s_d.tmr_fast && pll_en;

      // pin function takeover
      s_d.pins.port_b_line_four_clk =
         (s_d.fz.clock_select_fuses == CLOCK_SELECT_FUSES_EXT) ||
         s_d.fz.clock_select_fuses[3] ||
         (s_d.fz.clock_select_fuses[3:2] == CLOCK_SELECT_FUSES_LFX_TOP);
      s_d.pins.port_b_line_five_xtal =
         s_d.fz.clock_select_fuses[3] ||
         (s_d.fz.clock_select_fuses[3:2] == CLOCK_SELECT_FUSES_LFX_TOP);
   end

   // ************************************************************
   // registers
   // ************************************************************
   // reset holds everything quiet except the converter clock enable adc_en
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
         s_q.st <= ST_LATCH;
         s_q.fz <= FUSE_DEFAULT;
         s_q.slp <= SLP_IDLE;
         s_q.pll_sw_enable <= CSR_RST[CSR_EN_BIT];
         s_q.half <= CSR_RST[CSR_HALF_BIT];
         s_q.tmr_fast <= CSR_RST[CSR_TMR_BIT];
         s_q.gate <= GATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // outputs, all straight from flops
   // ************************************************************
   assign reg_rdata = s_q.rdata;
   assign gate_out = s_q.gate;
   assign cfg_out = s_q.cfg;
   assign pin_out = s_q.pins;
   assign exec_en = s_q.exec;

   // xtal_sel kept for status decode symmetry
   logic unused_xtal;
   assign unused_xtal = xtal_sel;

endmodule // ccspll_clock_ctrl

// file: verif/ccspll_clock_ctrl_asserts.sv
// Port-level checker for the clock source and PLL start-up controller.
// Assumes it is bound onto ccspll_clock_ctrl and sees only its ports.
`timescale 1ns/100ps
module ccspll_chk #(
   parameter logic [13:0] WDT_LONG_CNT = ccspll_pkg::WDT_64MS,
   parameter logic [14:0] CK_LONG_CNT = ccspll_pkg::CK_16K
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic sleep_req,
   input ccspll_pkg::ccspll_slp_t sleep_mode,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input ccspll_pkg::ccspll_gate_t gate_out,
   input ccspll_pkg::ccspll_cfg_t cfg_out,
   input ccspll_pkg::ccspll_pin_t pin_out,
   input wire logic exec_en
);
   import ccspll_pkg::*;
   logic [11:0] run_cnt_q;
   logic [11:0] run_cnt_d;
   logic half_q;
   // ****************************
   // helper: cycles of unbroken pll running
   // ****************************
   // restarts on a rate change, as the loop must lock again
   always_comb begin
      run_cnt_d = run_cnt_q;
      if (!gate_out.pll_run || cfg_out.pll_half_rate_select != half_q) begin
         run_cnt_d = 12'h000;
      end else if (run_cnt_q != 12'hFFF) begin
         run_cnt_d = run_cnt_q + 12'h001;
      end
   end
   // registered copy of the counter and the rate bit
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         run_cnt_q <= 12'h000;
         half_q <= 1'b0;
      end else begin
         run_cnt_q <= run_cnt_d;
         half_q <= cfg_out.pll_half_rate_select;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   // ****************************
   // port relations
   // ****************************
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside the read slot");
   lock_time_a: assert property ($rose(gate_out.pll_lock_flag) |->
      run_cnt_q >= 12'd2400 && run_cnt_q <= 12'd2600)
      else $error("lock flag rose at the wrong time");
   lock_gone_a: assert property (!gate_out.pll_run && !$past(gate_out.pll_run)
      |-> !gate_out.pll_lock_flag) else $error("lock flag with pll stopped");
   pck_rate_a: assert property (gate_out.pll_run && $past(gate_out.pll_run) &&
      $stable(cfg_out.pll_half_rate_select) |-> cfg_out.pck_mhz ==
      (cfg_out.pll_half_rate_select ? 7'h20 : PCK_FULL_MHZ)) else $error("wrong fast clock rate");
   half_block_a: assert property (cfg_out.sys_src == CLOCK_SELECT_FUSES_PLL &&
      $past(cfg_out.sys_src) == CLOCK_SELECT_FUSES_PLL |-> !$rose(cfg_out.pll_half_rate_select))
      else $error("half rate set while pll clocks the system");
   pll_fuse_a: assert property (cfg_out.sys_src == CLOCK_SELECT_FUSES_PLL && gate_out.rc_run &&
      $past(cfg_out.sys_src) == CLOCK_SELECT_FUSES_PLL |-> gate_out.pll_run) else $error("pll not enabled");
   sys_div_a: assert property (exec_en |-> cfg_out.sys_div ==
      (cfg_out.sys_src == CLOCK_SELECT_FUSES_PLL ? SYS_PLL_DIV : SYS_NO_DIV)) else $error("wrong system divide");
   deep_stop_a: assert property (exec_en && sleep_req && (sleep_mode == SLP_PDOWN ||
      sleep_mode == SLP_STBY) |=> !gate_out.rc_run && !gate_out.pll_run && !exec_en)
      else $error("oscillators kept running in deep sleep");
   adc_own_a: assert property (exec_en && sleep_req && sleep_mode == SLP_ADCNR |=>
      gate_out.adc_en && !gate_out.io_en && !gate_out.cpu_en) else $error("converter clock gated");
   flash_cpu_a: assert property (gate_out.flash_en == gate_out.cpu_en &&
      gate_out.cpu_en == exec_en) else $error("flash clock apart from cpu clock");
   pin_map_a: assert property (exec_en |-> pin_out == {cfg_out.sys_src == CLOCK_SELECT_FUSES_EXT ||
      cfg_out.sys_src[3:2] != 2'h0, cfg_out.sys_src[3:2] != 2'h0}) else $error("wrong pin use");
endmodule // ccspll_chk

bind ccspll_clock_ctrl ccspll_chk #(.WDT_LONG_CNT(WDT_LONG_CNT), .CK_LONG_CNT(CK_LONG_CNT)) i_chk (
   .clk_sys(clk_sys), .arst_n(arst_n), .sleep_req(sleep_req), .sleep_mode(sleep_mode),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gate_out(gate_out), .cfg_out(cfg_out),
   .pin_out(pin_out), .exec_en(exec_en));

// file: verif/ccspll_clk_src.sv
// Model of the selected clock source: one tick every period cycles of clk_sys.
// Assumes run is driven synchronously; period of zero acts as sixteen.
`timescale 1ns/100ps
module ccspll_clk_src (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic run,
   input wire logic [3:0] period,
   output logic tick
);
   logic [3:0] cnt_q;
   // a stopped oscillator gives no ticks and restarts from zero phase
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 4'h0;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_q <= 4'h0;
         tick <= 1'b0;
      end else begin
         cnt_q <= (cnt_q + 4'h1 == period) ? 4'h0 : cnt_q + 4'h1;
         tick <= (cnt_q + 4'h1 == period);
      end
   end
endmodule // ccspll_clk_src

// file: verif/tb_top.sv
// Self-checking bench for the clock source and PLL start-up controller.
// Assumes a shortened long watchdog count of 20 and a source tick every 8 cycles.
`timescale 1ns/100ps
module tb_top;
   import ccspll_pkg::*;
   logic clk_sys, arst_n, fuse_blank, sel_clk_tick, sleep_req, wake_evt, reg_wr, reg_rd;
   logic exec_en, src_on, rd_prev;
   ccspll_fuse_t fuse_in;
   ccspll_slp_t sleep_mode;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, lfsr_q;
   ccspll_gate_t gate_out;
   ccspll_cfg_t cfg_out;
   ccspll_pin_t pin_out;
   logic [7:0] exp_q[$];
   int n_fail, comparisons, n;
   logic [3:0] codes [7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC, 4'hF};
   ccspll_slp_t modes [5] = '{SLP_IDLE, SLP_ADCNR, SLP_PSAVE, SLP_PDOWN, SLP_STBY};
   logic [7:0] gexp [5] = '{8'h2E, 8'h0E, 8'h06, 8'h00, 8'h00};
   int lo [5] = '{1, 1, 48, 48, 48};
   int hi [5] = '{4, 4, 55, 55, 55};

   ccspll_clock_ctrl #(.WDT_LONG_CNT(14'h0014), .CK_LONG_CNT(15'h0028)) i_ccspll_clock_ctrl (
      .clk_sys(clk_sys), .arst_n(arst_n), .fuse_in(fuse_in), .fuse_blank(fuse_blank),
      .sel_clk_tick(sel_clk_tick), .sleep_req(sleep_req), .sleep_mode(sleep_mode),
      .wake_evt(wake_evt), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gate_out(gate_out), .cfg_out(cfg_out),
      .pin_out(pin_out), .exec_en(exec_en));
   ccspll_clk_src i_ccspll_clk_src (.clk_sys(clk_sys), .arst_n(arst_n), .run(src_on),
      .period(4'h8), .tick(sel_clk_tick));

   // ****************************
   // helpers
   // ****************************
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // a gap cycle follows every strobe, so no strobe is driven twice at one edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask
   task automatic do_reset(input ccspll_fuse_t f, input logic blank);
      @(posedge clk_sys);
      arst_n <= 1'b0;
      fuse_in <= f;
      fuse_blank <= blank;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
   endtask
   // bounded wait for execution, then the elapsed cycle count must fit the window
   task automatic wait_exec(input int lo_c, input int hi_c);
      // first look one half period on, clear of the edge that may launch exec_en
      n = 1;
      @(negedge clk_sys);
      while (exec_en !== 1'b1 && n < 6000) begin
         @(negedge clk_sys);
         n++;
      end
      check(8'(n >= lo_c && n <= hi_c), 8'h01);
   endtask
   task automatic summarize;
      if (n_fail == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // read data is due at the falling edge of the cycle after the strobe
   always @(negedge clk_sys) begin
      if (rd_prev) check(reg_rdata, exp_q.pop_front());
      rd_prev = reg_rd;
   end
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_fail++;
      summarize();
   end

   // ****************************
   // scenarios
   // ****************************
   initial begin
      {arst_n, fuse_blank, sleep_req, wake_evt, reg_wr, reg_rd, rd_prev} = 7'h00;
      {fuse_in, reg_addr, reg_wdata} = '0;
      sleep_mode = SLP_IDLE;
      src_on = 1'b1;
      lfsr_q = 8'h4B;
      n_fail = 0;
      comparisons = 0;
      // blank fuses: shipped default wins over whatever the fuse inputs show
      do_reset(ccspll_fuse_t'(lfsr_q[6:0]), 1'b1);
      wait_exec(3705, 4030);
      rd(REG_CLK_STAT, 8'h94);
      fuse_in <= ccspll_fuse_t'(7'h7F);
      rd(REG_CLK_STAT, 8'h94);
      @(negedge clk_sys);
      check(8'({cfg_out.sys_div, cfg_out.div8_init}), 8'h03);
      foreach (codes[i]) begin
         do_reset('{codes[i], SUT_NONE, 1'b1}, 1'b0);
         wait_exec(112, 119);
         rd(REG_CLK_STAT, {1'b1, codes[i], 3'h1});
         check(8'({pin_out, cfg_out.sys_src}), 8'({codes[i] == 4'h0 ||
            codes[i][3:2] != 2'h0, codes[i][3:2] != 2'h0, codes[i]}));
      end
      // software enable with fast timer select, then wait past the lock count
      wr(REG_PLL_CSR, 8'h0A);
      repeat (2600) @(posedge clk_sys);
      rd(REG_PLL_CSR, 8'h0B);
      @(negedge clk_sys);
      check(8'({cfg_out.pck_mhz, cfg_out.tmr_fast_sel}), 8'({PCK_FULL_MHZ, 1'b1}));
      wr(REG_PLL_CSR, 8'h0E);
      rd(REG_PLL_CSR, 8'h0E);
      @(negedge clk_sys);
      check(8'(cfg_out.pck_mhz), 8'h20);
      rd(4'h5, 8'h00);
      wr(REG_CLK_STAT, 8'h00);
      rd(REG_CLK_STAT, 8'hF9);
      repeat (4) begin
         lfsr_q = lfsr(lfsr_q);
         wr(REG_PLL_CSR, lfsr_q & 8'hFD);
         rd(REG_PLL_CSR, lfsr_q & 8'h0C);
      end
      wr(REG_PLL_CSR, 8'h02);
      foreach (modes[i]) begin
         @(posedge clk_sys);
         sleep_req <= 1'b1;
         sleep_mode <= modes[i];
         src_on <= (modes[i] <= SLP_ADCNR);
         @(posedge clk_sys);
         sleep_req <= 1'b0;
         repeat (3) @(negedge clk_sys);
         check(8'(gate_out), gexp[i]);
         @(posedge clk_sys);
         wake_evt <= 1'b1;
         src_on <= 1'b1;
         @(posedge clk_sys);
         wake_evt <= 1'b0;
         wait_exec(lo[i], hi[i]);
      end
      // loop clock as system source: long start-up, half rate refused
      do_reset('{CLOCK_SELECT_FUSES_PLL, SUT_NONE, 1'b0}, 1'b0);
      repeat (2) @(posedge clk_sys);
      wr(REG_PLL_CSR, 8'h04);
      rd(REG_PLL_CSR, 8'h00);
      @(negedge clk_sys);
      check(8'({cfg_out.sys_div, pin_out, gate_out.pll_run}), 8'h21);
      repeat (2600) @(posedge clk_sys);
      rd(REG_PLL_CSR, 8'h01);
      check(8'(exec_en), 8'h00);
      summarize();
   end
endmodule // tb_top
